// file: core/msp_pkg.sv
// Constants and carrier types for the modem-side serial port.
// Assumes one 10 MHz system clock and an active-high asynchronous reset.
// How it works
// - Eight wires: data pair, send request/clearance, set/terminal ready, carrier, call alert.
// - Bit rate divider reaches up to about 909 Kbit/s (divider 11) from the system clock.
// - Inputs: data, send request, terminal ready; outputs: data, clearance, status lines.
// - In reset data out high; clearance, set ready, carrier and call alert undriven.
// - Port enabled and shared pins as general I/O exclude each other.
// - Send request and clearance form hardware flow control against overrun.
// - Stay in fast idle while terminal ready is high.
package msp_pkg;
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          MAX_BAUD        = 921_600;
	localparam int          DIV_W           = 16;
	// Fastest divider: ceil of clock over top rate (11 cycles)
	localparam logic [15:0] DIV_MIN         = 16'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
	localparam logic [15:0] DIV_RESET       = 16'h0057;
	localparam int          DATA_BITS       = 8;
	localparam int          RX_DEPTH        = 16;
	localparam int          RX_NEAR_FULL    = 12;

	typedef struct packed {
		logic rx_data;
		logic send_request;
		logic terminal_ready;
	} msp_pin_in_s;

	typedef struct packed {
		logic tx_data;
		logic tx_data_oe_n;
		logic clearance;
		logic clearance_oe_n;
		logic set_ready;
		logic set_ready_oe_n;
		logic carrier;
		logic carrier_oe_n;
		logic call_alert;
		logic call_alert_oe_n;
	} msp_pin_out_s;

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} msp_bit_e;
endpackage

// file: core/msp_rx_mem.sv
// Small receive memory, registered read data.
// Assumes caller never writes when full nor reads when empty.
`timescale 1ns/1ps
module msp_rx_mem import msp_pkg::*; #(
	parameter int W = 8,
	parameter int D = 16,
	parameter int AW = $clog2(D)
) (
	input  wire logic          sys_clk,
	input  wire logic          ce,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem [D];
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule // msp_rx_mem

// file: core/msp_port.sv
// Modem-side serial port: transmitter, receiver, flow control and status lines.
// Assumes pins arrive asynchronous; user side is on sys_clk.
`timescale 1ns/1ps
module msp_port import msp_pkg::*; #(
	parameter int DEPTH = RX_DEPTH
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire msp_pin_in_s       pins_in,
	output msp_pin_out_s           pins_out,
	input  wire logic              port_enable,
	input  wire logic              gpio_claim,
	output logic                   port_active,
	input  wire logic              flow_enable,
	input  wire logic [DIV_W-1:0]  baud_div,
	input  wire logic              tx_valid,
	input  wire logic [7:0]        tx_byte,
	output logic                   tx_ready,
	output logic                   rx_valid,
	output logic [7:0]             rx_byte,
	input  wire logic              rx_ready,
	output logic                   rx_overrun,
	input  wire logic              set_ready_in,
	input  wire logic              carrier_in,
	input  wire logic              call_alert_in,
	output logic                   host_terminal_ready,
	output logic                   fast_idle
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [2:0]       sy_rx;
		logic [2:0]       sy_rts;
		logic [2:0]       sy_dtr;
		logic             active;
		msp_bit_e         tx_st;
		logic [DIV_W-1:0] tx_cnt;
		logic [2:0]       tx_bit;
		logic [7:0]       tx_sh;
		logic             tx_line;
		msp_bit_e         rx_st;
		logic [DIV_W-1:0] rx_cnt;
		logic [2:0]       rx_bit;
		logic [7:0]       rx_sh;
		logic [AW:0]      wp;
		logic [AW:0]      rp;
		logic             ovr;
		logic             out_v;
		logic             rd_pend;
		logic             clr;
		logic             dtr;
	} msp_state_s;

	msp_state_s st;
	msp_state_s next_st;
	logic [7:0] mem_rd;
	logic       mem_wr;
	logic [DIV_W-1:0] div;

	// Entries held in memory; the extra pointer bit tells full from empty
	function automatic logic [AW:0] fill(input logic [AW:0] w, input logic [AW:0] r);
		logic [AW:0] diff;
		diff = w - r;
		return diff;
	endfunction

	assign div = (baud_div < DIV_MIN) ? DIV_MIN : baud_div;

	always_comb begin
		next_st = st;
		mem_wr = 1'b0;
		// Pin synchronisers; receive data has a third stage for start search
		next_st.sy_rx = {st.sy_rx[1:0], pins_in.rx_data};
		next_st.sy_rts = {st.sy_rts[1:0], pins_in.send_request};
		next_st.sy_dtr = {st.sy_dtr[1:0], pins_in.terminal_ready};
		next_st.active = port_enable & ~gpio_claim;
		next_st.dtr = st.sy_dtr[1];
		case (st.tx_st)
			ST_IDLE: begin
				next_st.tx_line = 1'b1;
				if (st.active && tx_valid && (!flow_enable || st.sy_rts[1])) begin
					next_st.tx_sh = tx_byte;
					next_st.tx_cnt = div - 1'b1;
					next_st.tx_line = 1'b0;
					next_st.tx_st = ST_START;
				end
			end
			ST_START, ST_DATA, ST_STOP: begin
				if (st.tx_cnt != '0) begin
					next_st.tx_cnt = st.tx_cnt - 1'b1;
				end else begin
					next_st.tx_cnt = div - 1'b1;
					if (st.tx_st == ST_START) begin
						next_st.tx_st = ST_DATA;
						next_st.tx_bit = '0;
						next_st.tx_line = st.tx_sh[0];
					end else if (st.tx_st == ST_DATA) begin
						next_st.tx_bit = st.tx_bit + 1'b1;
						if (st.tx_bit == 3'(DATA_BITS - 1)) begin
							next_st.tx_st = ST_STOP;
							next_st.tx_line = 1'b1;
						end else begin
							next_st.tx_line = st.tx_sh[st.tx_bit + 1'b1];
						end
					end else begin
						next_st.tx_st = ST_IDLE;
					end
				end
			end
			default: next_st.tx_st = ST_IDLE;
		endcase
		case (st.rx_st)
			ST_IDLE: begin
				if (st.active && !st.sy_rx[2]) begin
					next_st.rx_cnt = {1'b0, div[DIV_W-1:1]};
					next_st.rx_st = ST_START;
				end
			end
			ST_START, ST_DATA, ST_STOP: begin
				if (st.rx_cnt != '0) begin
					next_st.rx_cnt = st.rx_cnt - 1'b1;
				end else begin
					next_st.rx_cnt = div - 1'b1;
					if (st.rx_st == ST_START) begin
						next_st.rx_st = st.sy_rx[2] ? ST_IDLE : ST_DATA;
						next_st.rx_bit = '0;
					end else if (st.rx_st == ST_DATA) begin
						next_st.rx_sh = {st.sy_rx[2], st.rx_sh[7:1]};
						next_st.rx_bit = st.rx_bit + 1'b1;
						if (st.rx_bit == 3'(DATA_BITS - 1)) begin
							next_st.rx_st = ST_STOP;
						end
					end else begin
						next_st.rx_st = ST_IDLE;
						if (st.sy_rx[2]) begin
							if (fill(st.wp, st.rp) == (AW+1)'(DEPTH)) begin
								next_st.ovr = 1'b1;
							end else begin
								mem_wr = 1'b1;
								next_st.wp = st.wp + 1'b1;
							end
						end
					end
				end
			end
			default: next_st.rx_st = ST_IDLE;
		endcase
		// Output stage fed from memory with one-cycle read latency
		if (rx_valid && rx_ready) begin
			next_st.out_v = 1'b0;
		end
		next_st.rd_pend = 1'b0;
		if (!st.rd_pend && (!st.out_v || (rx_valid && rx_ready)) && st.rp != st.wp) begin
			next_st.rd_pend = 1'b1;
			next_st.rp = st.rp + 1'b1;
		end
		if (st.rd_pend) begin
			next_st.out_v = 1'b1;
		end
		next_st.clr = st.active && (!flow_enable ||
			fill(st.wp, st.rp) < (AW+1)'(RX_NEAR_FULL));
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st <= '{sy_rx: 3'h7, sy_rts: 3'h0, sy_dtr: 3'h0, tx_st: ST_IDLE, rx_st: ST_IDLE,
				tx_line: 1'b1, tx_cnt: DIV_RESET, rx_cnt: DIV_RESET, default: '0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	msp_rx_mem #(.W(8), .D(DEPTH)) u_mem (
		.sys_clk (sys_clk),
		.ce      (ce),
		.wr_en   (mem_wr),
		.wr_addr (st.wp[AW-1:0]),
		.wr_data (st.rx_sh),
		.rd_addr (st.rp[AW-1:0]),
		.rd_data (mem_rd)
	);

	// Read data register, loaded one cycle after the memory read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_byte <= 8'h00;
		end else if (ce && st.rd_pend) begin
			rx_byte <= mem_rd;
		end
	end

	assign rx_valid = st.out_v;
	assign rx_overrun = st.ovr;
	assign tx_ready = st.active && st.tx_st == ST_IDLE && (!flow_enable || st.sy_rts[1]);
	assign port_active = st.active;
	assign host_terminal_ready = st.dtr;
	// fast idle held by terminal ready
	assign fast_idle = st.dtr;

	// pin directions; reset keeps data high, others undriven
	always_comb begin
		pins_out.tx_data = st.tx_line;
		pins_out.tx_data_oe_n = 1'b0;
		pins_out.clearance = st.clr;
		pins_out.clearance_oe_n = ~st.active;
		pins_out.set_ready = set_ready_in;
		pins_out.set_ready_oe_n = ~st.active;
		pins_out.carrier = carrier_in;
		pins_out.carrier_oe_n = ~st.active;
		pins_out.call_alert = call_alert_in;
		pins_out.call_alert_oe_n = ~st.active;
	end
endmodule // msp_port

// file: verification/msp_port_chk.sv
// Pin-level assertions for msp_port.
// Assumes checking pauses while ce is low.
`timescale 1ns/1ps
module msp_port_chk import msp_pkg::*; (
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire logic         ce,
	input wire msp_pin_in_s  pins_in,
	input wire msp_pin_out_s pins_out,
	input wire logic         gpio_claim,
	input wire logic         port_active,
	input wire logic         flow_enable,
	input wire logic         tx_valid,
	input wire logic         tx_ready,
	input wire logic         rx_valid,
	input wire logic [7:0]   rx_byte,
	input wire logic         rx_ready,
	input wire logic         host_terminal_ready,
	input wire logic         fast_idle
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst || !ce);
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	sequence s_start;
		(!pins_out.tx_data && !tx_ready) [*8];
	endsequence
	property p_rst;
		$fell(rst) |-> pins_out.tx_data && pins_out.clearance_oe_n;
	endproperty
	property p_start;
		s_take |=> s_start;
	endproperty
	property p_flow;
		(flow_enable && !pins_in.send_request) [*4] |-> !tx_ready;
	endproperty
	property p_flow_off;
		(!flow_enable && port_active) [*3] |-> pins_out.clearance;
	endproperty
	property p_claim;
		gpio_claim [*3] |-> !port_active;
	endproperty
	property p_drive;
		port_active [*2] |-> !pins_out.set_ready_oe_n && !pins_out.clearance_oe_n;
	endproperty
	property p_idle;
		pins_in.terminal_ready [*4] |-> fast_idle && host_terminal_ready;
	endproperty
	property p_rx_hold;
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte);
	endproperty
	a_rst: assert property (p_rst) else $error("reset pins");
	a_start: assert property (p_start) else $error("start bit");
	a_flow: assert property (p_flow) else $error("send held");
	a_flow_off: assert property (p_flow_off) else $error("clearance");
	a_claim: assert property (p_claim) else $error("claim");
	a_drive: assert property (p_drive) else $error("drive");
	a_idle: assert property (p_idle) else $error("idle");
	a_rx_hold: assert property (p_rx_hold) else $error("rx hold");
endmodule // msp_port_chk

bind msp_port msp_port_chk chk_u (
	.sys_clk             (sys_clk),
	.rst                 (rst),
	.ce                  (ce),
	.pins_in             (pins_in),
	.pins_out            (pins_out),
	.gpio_claim          (gpio_claim),
	.port_active         (port_active),
	.flow_enable         (flow_enable),
	.tx_valid            (tx_valid),
	.tx_ready            (tx_ready),
	.rx_valid            (rx_valid),
	.rx_byte             (rx_byte),
	.rx_ready            (rx_ready),
	.host_terminal_ready (host_terminal_ready),
	.fast_idle           (fast_idle)
);

// file: verification/msp_host_model.sv
// Host serial model: drives the host data line, decodes device frames.
// Assumes div cycles per bit on both sides.
`timescale 1ns/1ps
module msp_host_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] div,
	input  wire logic        tx_line,
	output logic             rx_line
);
	logic [7:0] got[$];
	logic [7:0] b;
	initial rx_line = 1'b1;
	task automatic send(input logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			rx_line = i == 0 ? 1'b0 : i == 9 ? 1'b1 : d[i - 1];
			repeat (div) @(posedge sys_clk);
			#1;
		end
	endtask
	initial forever begin
		@(negedge tx_line);
		repeat (div / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge sys_clk);
			b[i] = tx_line;
		end
		repeat (div) @(posedge sys_clk);
		if (tx_line)
			got.push_back(b);
	end
endmodule // msp_host_model

// file: verification/modem_serial_port_tb_top.sv
// Self-checking bench for msp_port with a host model on its pins.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
module modem_serial_port_tb_top import msp_pkg::*; ;
	localparam logic [15:0] DIV = 16'h000b;
	logic         sys_clk, rst, tx_valid, tx_ready, rx_valid, rx_ready;
	logic         rts, dtr, flow, claim, line, act, ovr, htr, fidle, ce;
	logic [2:0]   st;
	logic [7:0]   tx_byte, rx_byte, b;
	logic [7:0]   q[$];
	msp_pin_out_s po;
	int           bad_count, n_compared, seed, i;

	msp_port dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .pins_in({line, rts, dtr}),
		.pins_out(po), .port_enable(1'b1), .gpio_claim(claim), .port_active(act),
		.flow_enable(flow), .baud_div(DIV), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
		.rx_overrun(ovr), .set_ready_in(st[2]), .carrier_in(st[1]), .call_alert_in(st[0]),
		.host_terminal_ready(htr), .fast_idle(fidle));
	msp_host_model host_u (.sys_clk(sys_clk), .div(DIV), .tx_line(po.tx_data), .rx_line(line));

	// Clearance expected while fewer than the near-full count are held
	function automatic logic [7:0] exp_clear(input int held);
		return {7'h00, held < RX_NEAR_FULL};
	endfunction
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic lim;
		if (i >= 3000) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic put(input logic [7:0] d);
		tx_valid = 1;
		tx_byte = d;
		for (i = 0; i < 3000 && tx_ready !== 1'b1; i++)
			tick(1);
		lim();
		tick(1);
		tx_valid = 0;
		tick(11 * DIV);
		check(host_u.got.pop_front(), d);
	endtask
	task automatic get;
		for (i = 0; i < 3000 && rx_valid !== 1'b1; i++)
			tick(1);
		lim();
		check(rx_byte, q.pop_front());
		rx_ready = 1;
		tick(1);
		rx_ready = 0;
		tick(1);
	endtask

	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		seed = 32'hf7ba6632;
		ce = 1;
		{rst, rts, dtr, flow, tx_valid, rx_ready, claim, st, tx_byte} = {4'hf, 14'h0000};
		tick(20);
		check({6'h00, po.tx_data, po.clearance_oe_n}, 8'h03);
		rst = 0;
		tick(4);
		$display("reset done");
		for (int k = 0; k < 4; k++) begin
			st = 3'($random(seed));
			claim = k[0];
			tick(3);
			check({6'h00, act, po.set_ready_oe_n}, {6'h00, !k[0], k[0]});
			if (!k[0])
				check({5'h00, po.set_ready, po.carrier, po.call_alert}, {5'h00, st});
		end
		// Hand the shared pins back to the port before any traffic
		claim = 0;
		tick(3);
		// Clock enable low freezes the port
		ce = 0;
		claim = 1;
		tick(2);
		check({7'h00, act}, 8'h01);
		claim = 0;
		ce = 1;
		tick(2);
		check({7'h00, act}, 8'h01);
		$display("pins done");
		for (int k = 0; k < 6; k++)
			put(k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($random(seed)));
		// host withholds send request before a byte is offered
		rts = 0;
		tick(4);
		tx_valid = 1;
		tick(40);
		check({7'h00, tx_ready}, 8'h00);
		check({7'h00, po.tx_data}, 8'h01);
		check(8'(host_u.got.size()), 8'h00);
		rts = 1;
		put(8'ha5);
		$display("tx done");
		for (int k = 0; k < 18; k++) begin
			b = 8'($random(seed));
			host_u.send(b);
			// One byte waits in the output register, sixteen in memory
			if (k < 17)
				q.push_back(b);
			check({7'h00, po.clearance}, exp_clear(k));
			check({7'h00, ovr}, {7'h00, k == 17});
		end
		tick(6);
		check({7'h00, ovr}, 8'h01);
		// flow off stands for a two-wire link to an attached chip
		flow = 0;
		rts = 0;
		tick(4);
		check({7'h00, po.clearance}, 8'h01);
		check({7'h00, tx_ready}, 8'h01);
		flow = 1;
		rts = 1;
		for (int k = 0; k < 17; k++)
			get();
		$display("rx done");
		// host drives terminal ready low, then high
		for (int k = 0; k < 2; k++) begin
			dtr = k[0];
			tick(4);
			check({6'h00, htr, fidle}, {6'h00, k[0], k[0]});
		end
		$display("idle done");
		conclude();
	end
endmodule // modem_serial_port_tb_top
